// [core/smi_if.sv]
// Purpose: management clock and shared data line between station and slave
// Assumes: pull-up keeps the line high when nobody drives
// Notes: line level is resolved here from the two enables
`timescale 1ns/100ps
interface smi_if;
  logic mdc;      // management clock from the station
  logic sta_o;    // station data out
  logic sta_oe;   // station drives the line
  logic phy_o;    // slave data out
  logic phy_oe;   // slave drives the line
  logic mdio;     // resolved line level
  // pull-up wins when the line floats
  assign mdio = phy_oe ? phy_o : (sta_oe ? sta_o : 1'b1);
  modport phy (input mdc, input mdio, output phy_o, output phy_oe);
  modport station_manager (output mdc, output sta_o, output sta_oe, input mdio);
endinterface : smi_if

// [core/smi_phy_slave.sv]
// Purpose: management slave with direct and indirect extended register access
// Assumes: management clock no faster than clk/8, sampled as a plain input
// Notes: no timeouts, so a stopped management clock simply freezes the frame
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module smi_phy_slave #(
  parameter int EXT_AW = 4 // address bits kept per extended space
) (
  input wire logic clk,
  input wire logic rst_n,
  smi_if.phy bus,
  input wire logic [4:0] bus_address_straps,
  output logic [4:0] phy_addr,
  output logic frame_done
);
  // ----------------------------------------
  // types and storage
  // ----------------------------------------
  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_START = 5'b00010,
    PS_HDR = 5'b00100,
    PS_TA = 5'b01000,
    PS_DATA = 5'b10000
  } smi_pstate_t;

  smi_pstate_t state;
  logic mdc_s1, mdc_s2, mdc_s3; // clock synchroniser and edge history
  logic mdio_s1, mdio_s2;       // data synchroniser
  logic [4:0] strap_s1, strap_s2;
  logic [1:0] strap_cnt;        // settle count before latching
  logic strap_done;
  logic [4:0] cnt;              // bit count inside a field
  logic [10:0] hdr;             // header bits gathered so far
  logic [14:0] rx;              // data bits gathered so far
  logic [15:0] tx;              // read data shifter
  logic is_rd, is_wr;           // frame kind, valid only on address hit
  logic [4:0] ra;               // latched register address
  logic [15:0] regs [32];       // direct register set
  logic [15:0] ext_mem [3][2**EXT_AW]; // extended spaces
  logic [15:0] mmd_access_control;
  logic [15:0] ext_ptr;         // extended address pointer
  logic rise;
  logic [11:0] hdr_full;
  logic hdr_end, data_end;
  logic [15:0] wdata;
  logic [15:0] next_rd;

  // selector to space index, 3 means not honoured
  function automatic logic [1:0] dev_index(input logic [4:0] sel);
    case (sel)
      smi_pkg::SMI_DEV_VENDOR: dev_index = 2'h0;
      smi_pkg::SMI_DEV_EEE_PCS: dev_index = 2'h1;
      smi_pkg::SMI_DEV_EEE_AN: dev_index = 2'h2;
      default: dev_index = 2'h3;
    endcase
  endfunction : dev_index

  // vendor pointer below 32 maps onto the direct set
  function automatic logic vendor_low(input logic [1:0] idx, input logic [15:0] ptr);
    vendor_low = (idx == 2'h0) && (ptr[15:5] == 11'h000);
  endfunction : vendor_low

  logic [1:0] fn;
  logic [1:0] didx;
  assign fn = mmd_access_control[smi_pkg::SMI_FUNC_MSB:smi_pkg::SMI_FUNC_LSB];
  assign didx = dev_index(mmd_access_control[smi_pkg::SMI_DEVSEL_MSB:0]);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // two flops on clock and data, third flop only for edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= bus.mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= bus.mdio;
      mdio_s2 <= mdio_s1;
    end
  end

  assign rise = mdc_s2 & ~mdc_s3;
  assign hdr_full = {hdr, mdio_s2};
  assign wdata = {rx, mdio_s2};
  assign hdr_end = rise && (state == PS_HDR) && (cnt == 5'(smi_pkg::SMI_HDR_BITS - 1));
  assign data_end = rise && (state == PS_DATA) && (cnt == 5'(smi_pkg::SMI_DATA_BITS - 1));

  // ----------------------------------------
  // bus address straps
  // ----------------------------------------
  // latch straps after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1 <= 5'h00;
      strap_s2 <= 5'h00;
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      phy_addr <= 5'h00;
    end else begin
      strap_s1 <= bus_address_straps;
      strap_s2 <= strap_s1;
      if (!strap_done) begin
        if (strap_cnt == 2'(smi_pkg::SMI_STRAP_SETTLE)) begin
          phy_addr <= strap_s2;
          strap_done <= 1'b1;
        end else begin
          strap_cnt <= strap_cnt + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // frame decoder
  // ----------------------------------------
  // advances only on clock edges, no timeout
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PS_IDLE;
      cnt <= 5'h00;
      hdr <= 11'h000;
      rx <= 15'h0000;
      is_rd <= 1'b0;
      is_wr <= 1'b0;
      ra <= 5'h00;
    end else if (rise && strap_done) begin
      case (state)
        PS_IDLE: begin
          if (!mdio_s2) begin
            state <= PS_START;
          end
        end
        // repeated zeros keep waiting for the one
        PS_START: begin
          if (mdio_s2) begin
            state <= PS_HDR;
            cnt <= 5'h00;
          end
        end
        PS_HDR: begin
          hdr <= hdr_full[10:0];
          cnt <= cnt + 5'h01;
          if (hdr_end) begin
            is_rd <= (hdr_full[11:10] == smi_pkg::SMI_OP_READ) &&
                     (hdr_full[9:5] == phy_addr);
            is_wr <= (hdr_full[11:10] == smi_pkg::SMI_OP_WRITE) &&
                     (hdr_full[9:5] == phy_addr);
            ra <= hdr_full[4:0];
            state <= PS_TA;
            cnt <= 5'h00;
          end
        end
        PS_TA: begin
          cnt <= cnt + 5'h01;
          if (cnt == 5'h01) begin
            state <= PS_DATA;
            cnt <= 5'h00;
          end
        end
        // data bits, most significant first
        PS_DATA: begin
          rx <= wdata[14:0];
          cnt <= cnt + 5'h01;
          if (data_end) begin
            state <= PS_IDLE;
            cnt <= 5'h00;
          end
        end
        default: state <= PS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read value
  // ----------------------------------------
  always_comb begin
    next_rd = smi_pkg::SMI_REG_RESET;
    if (hdr_full[4:0] == smi_pkg::SMI_REG_MMD_CTRL) begin
      next_rd = mmd_access_control;
    end else if (hdr_full[4:0] == smi_pkg::SMI_REG_MMD_ADDR_DATA) begin
      if (didx != 2'h3) begin
        if (fn == smi_pkg::SMI_FN_ADDR) begin
          next_rd = ext_ptr;
        end else if (vendor_low(didx, ext_ptr)) begin
          // indirect reach of control/data gives zero
          if (ext_ptr[4:0] != smi_pkg::SMI_REG_MMD_CTRL &&
              ext_ptr[4:0] != smi_pkg::SMI_REG_MMD_ADDR_DATA) begin
            next_rd = regs[ext_ptr[4:0]];
          end
        end else begin
          next_rd = ext_mem[didx][ext_ptr[EXT_AW-1:0]];
        end
      end
    end else begin
      next_rd = regs[hdr_full[4:0]];
    end
  end

  // ----------------------------------------
  // data line drive
  // ----------------------------------------
  // float first turnaround bit, zero, then data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.phy_o <= 1'b1;
      bus.phy_oe <= 1'b0;
      tx <= 16'h0000;
    end else if (rise) begin
      if (hdr_end) begin
        tx <= next_rd;
      end else if (state == PS_TA && is_rd) begin
        if (cnt == 5'h00) begin
          bus.phy_o <= 1'b0;
          bus.phy_oe <= 1'b1;
        end else begin
          bus.phy_o <= tx[15];
          tx <= {tx[14:0], 1'b0};
        end
      end else if (state == PS_DATA && is_rd && !data_end) begin
        bus.phy_o <= tx[15];
        tx <= {tx[14:0], 1'b0};
      end else begin
        bus.phy_o <= 1'b1;
        bus.phy_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register storage and pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mmd_access_control <= smi_pkg::SMI_CTRL_RESET;
      ext_ptr <= smi_pkg::SMI_PTR_RESET;
      frame_done <= 1'b0;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= smi_pkg::SMI_REG_RESET;
      end
      for (int d = 0; d < 3; d++) begin
        for (int j = 0; j < 2**EXT_AW; j++) begin
          ext_mem[d][j] <= smi_pkg::SMI_REG_RESET;
        end
      end
    end else begin
      frame_done <= data_end && (is_rd || is_wr);
      if (data_end && is_wr) begin
        if (ra == smi_pkg::SMI_REG_MMD_CTRL) begin
          mmd_access_control <= wdata;
        end else if (ra == smi_pkg::SMI_REG_MMD_ADDR_DATA) begin
          if (didx != 2'h3) begin
            if (fn == smi_pkg::SMI_FN_ADDR) begin
              ext_ptr <= wdata;
            end else begin
              if (vendor_low(didx, ext_ptr)) begin
                if (ext_ptr[4:0] != smi_pkg::SMI_REG_MMD_CTRL &&
                    ext_ptr[4:0] != smi_pkg::SMI_REG_MMD_ADDR_DATA) begin
                  regs[ext_ptr[4:0]] <= wdata;
                end
              end else begin
                ext_mem[didx][ext_ptr[EXT_AW-1:0]] <= wdata;
              end
              if (fn != smi_pkg::SMI_FN_DATA) begin
                ext_ptr <= ext_ptr + 16'h0001;
              end
            end
          end
        end else begin
          regs[ra] <= wdata;
        end
      end else if (data_end && is_rd && ra == smi_pkg::SMI_REG_MMD_ADDR_DATA) begin
        // increment after read, function 10 only
        if (didx != 2'h3 && fn == smi_pkg::SMI_FN_INC_RW) begin
          ext_ptr <= ext_ptr + 16'h0001;
        end
      end
    end
  end
endmodule : smi_phy_slave

// [core/smi_pkg.sv]
// Purpose: shared constants for the serial management slave and station
// Assumes: 100 MHz system clock on both ends
// Notes: frame fields are sent most significant bit first
package smi_pkg;
  // ----------------------------------------
  // frame fields
  // ----------------------------------------
  localparam logic [1:0] SMI_START = 2'h1;    // start pattern 0 then 1
  localparam logic [1:0] SMI_OP_READ = 2'h2;
  localparam logic [1:0] SMI_OP_WRITE = 2'h1;
  localparam logic [1:0] SMI_TA_WRITE = 2'h2; // station fills turnaround
  localparam int SMI_HDR_BITS = 12;           // opcode, phy and register address
  localparam int SMI_DATA_BITS = 16;
  localparam int SMI_FRAME_BITS = 32;         // start through data
  localparam int SMI_PRE_BITS = 32;           // idle ones before each frame
  localparam int SMI_RD_DRIVE_POS = 14;       // station releases from here on reads
  localparam int SMI_RD_DATA_POS = 16;        // first data bit position
  // ----------------------------------------
  // indirect access registers
  // ----------------------------------------
  localparam logic [4:0] SMI_REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] SMI_REG_MMD_ADDR_DATA = 5'h0E;
  localparam int SMI_FUNC_MSB = 15;
  localparam int SMI_FUNC_LSB = 14;
  localparam int SMI_DEVSEL_MSB = 4;
  localparam logic [1:0] SMI_FN_ADDR = 2'h0;
  localparam logic [1:0] SMI_FN_DATA = 2'h1;
  localparam logic [1:0] SMI_FN_INC_RW = 2'h2;
  localparam logic [1:0] SMI_FN_INC_WR = 2'h3;
  localparam logic [4:0] SMI_DEV_VENDOR = 5'h1F;
  localparam logic [4:0] SMI_DEV_EEE_PCS = 5'h03;
  localparam logic [4:0] SMI_DEV_EEE_AN = 5'h07;
  localparam logic [15:0] SMI_CTRL_RESET = 16'h0000;
  localparam logic [15:0] SMI_PTR_RESET = 16'h0000;
  localparam logic [15:0] SMI_REG_RESET = 16'h0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SMI_CLK_PERIOD_NS = 10;
  localparam int SMI_MDC_MIN_PERIOD_NS = 40;  // 25 MHz ceiling
  localparam int SMI_MDC_HALF_MIN =
    (SMI_MDC_MIN_PERIOD_NS + 2 * SMI_CLK_PERIOD_NS - 1) / (2 * SMI_CLK_PERIOD_NS);
  localparam int SMI_MDC_HALF_CYC = 4;        // 80 ns clock, covers slave latency
  localparam int SMI_STRAP_SETTLE = 2;        // cycles before straps are latched
  // ----------------------------------------
  // station command registers
  // ----------------------------------------
  localparam logic [1:0] SMI_STA_CMD = 2'h0;
  localparam logic [1:0] SMI_STA_WDATA = 2'h1;
  localparam logic [1:0] SMI_STA_RDATA = 2'h2;
  localparam logic [1:0] SMI_STA_STATUS = 2'h3;
  localparam int SMI_CMD_WRITE_BIT = 15;
  localparam int SMI_CMD_PHY_LSB = 5;
endpackage : smi_pkg

// [core/smi_station.sv]
// Purpose: station manager issuing single management frames for software
// Assumes: software sequences indirect accesses through command registers
// Notes: management clock runs only while a frame is on the line
`timescale 1ns/100ps
module smi_station #(
  parameter int MDC_HALF = smi_pkg::SMI_MDC_HALF_CYC, // clk cycles per half period
  parameter int PRE_BITS = smi_pkg::SMI_PRE_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  smi_if.station_manager bus,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic busy
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam int TOT = PRE_BITS + smi_pkg::SMI_FRAME_BITS;
  logic [15:0] wdata_q;        // data for the next write frame
  logic [15:0] rx;             // read data gathered
  logic [TOT-1:0] sh;          // outgoing bit shifter
  logic [7:0] bit_cnt;
  logic [7:0] div;
  logic is_rd;
  logic mdio_s1, mdio_s2;      // line synchroniser
  logic start;
  logic [1:0] op;

  assign start = wr && (addr == smi_pkg::SMI_STA_CMD) && !busy;
  assign op = wdata[smi_pkg::SMI_CMD_WRITE_BIT] ? smi_pkg::SMI_OP_WRITE : smi_pkg::SMI_OP_READ;

  // ----------------------------------------
  // line synchroniser
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdio_s1 <= bus.mdio;
      mdio_s2 <= mdio_s1;
    end
  end

  // ----------------------------------------
  // command registers
  // ----------------------------------------
  // software orders indirect steps as frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdata_q <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      if (wr && addr == smi_pkg::SMI_STA_WDATA) begin
        wdata_q <= wdata;
      end
      if (rd) begin
        case (addr)
          smi_pkg::SMI_STA_RDATA: rdata <= rx;
          smi_pkg::SMI_STA_STATUS: rdata <= {15'h0000, busy};
          smi_pkg::SMI_STA_WDATA: rdata <= wdata_q;
          default: rdata <= 16'h0000;
        endcase
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  // clock half period from clk divider
  // preamble keeps line idle before each frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      is_rd <= 1'b0;
      sh <= '1;
      bit_cnt <= 8'h00;
      div <= 8'h00;
      rx <= 16'h0000;
      bus.mdc <= 1'b0;
      bus.sta_o <= 1'b1;
      bus.sta_oe <= 1'b0;
    end else if (start) begin
      // frame image, read data left floating
      sh <= {{PRE_BITS{1'b1}}, smi_pkg::SMI_START, op,
             wdata[9:smi_pkg::SMI_CMD_PHY_LSB], wdata[4:0],
             (op == smi_pkg::SMI_OP_WRITE) ? smi_pkg::SMI_TA_WRITE : 2'h3,
             (op == smi_pkg::SMI_OP_WRITE) ? wdata_q : 16'hFFFF};
      is_rd <= (op == smi_pkg::SMI_OP_READ);
      busy <= 1'b1;
      bit_cnt <= 8'h00;
      div <= 8'h00;
      bus.mdc <= 1'b0;
      bus.sta_o <= 1'b1;
      bus.sta_oe <= 1'b1;
    end else if (busy) begin
      div <= div + 8'h01;
      if (div == 8'(MDC_HALF - 1)) begin
        div <= 8'h00;
        bus.mdc <= ~bus.mdc;
        if (!bus.mdc) begin
          if (is_rd && bit_cnt >= 8'(PRE_BITS + smi_pkg::SMI_RD_DATA_POS)) begin
            rx <= {rx[14:0], mdio_s2};
          end
        end else if (bit_cnt == 8'(TOT - 1)) begin
          // last bit done, stop clock and release
          busy <= 1'b0;
          bus.sta_o <= 1'b1;
          bus.sta_oe <= 1'b0;
        end else begin
          bit_cnt <= bit_cnt + 8'h01;
          sh <= {sh[TOT-2:0], 1'b1};
          bus.sta_o <= sh[TOT-2];
          bus.sta_oe <= !(is_rd &&
            (bit_cnt + 8'h01) >= 8'(PRE_BITS + smi_pkg::SMI_RD_DRIVE_POS));
        end
      end
    end
  end
endmodule : smi_station

// [test/smi_link_props.sv]
// Purpose: wire timing checks between station and slave
// Assumes: one 100 MHz clock for both ends
// Notes: instantiated beside the interface
`timescale 1ns/100ps
module smi_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mdc,
  input wire logic sta_o,
  input wire logic sta_oe,
  input wire logic phy_o,
  input wire logic phy_oe,
  input wire logic mdio
);
  logic [7:0] oe_cnt; // cycles the slave has driven
  // counts while the slave drives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_cnt <= 8'h00;
    end else if (phy_oe) begin
      oe_cnt <= oe_cnt + 8'h01;
    end else begin
      oe_cnt <= 8'h00;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_mdc_high_len: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
    else $error("mdc high phase wrong");
  a_mdc_low_len: assert property ($fell(mdc) |-> !mdc [*4])
    else $error("mdc low phase short");
  a_no_contention: assert property (!(phy_oe && sta_oe))
    else $error("both ends drive the line");
  a_ta_float: assert property ($fell(sta_oe) |-> (!phy_oe && mdio) [*6])
    else $error("line not floating in turnaround");
  a_ta_zero: assert property ($rose(phy_oe) |-> !phy_o [*8])
    else $error("slave turnaround bit not zero");
  // slave drives the second turnaround bit and 16 data bits, 8 clk each
  a_drive_len: assert property ($fell(phy_oe) |-> oe_cnt inside {[8'h86:8'h8A]})
    else $error("slave drive length wrong");
  a_phy_edge: assert property ($changed(phy_oe) |-> $past(mdc, 2))
    else $error("slave changed away from rise");
  a_sta_edge: assert property ($changed({sta_o, sta_oe}) |-> !mdc)
    else $error("station changed while mdc high");
  c_read: cover property ($rose(phy_oe));
  c_release: cover property ($fell(sta_oe));
  c_clock: cover property ($rose(mdc));
endmodule : smi_link_props

// [test/test_smi_mmd_indirect_access.sv]
// Purpose: station and slave joined, direct and indirect access
// Assumes: straps 5'h05, default preamble and clock divider
// Notes: all expectations fixed by hand below
`timescale 1ns/100ps
module test_smi_mmd_indirect_access;
  localparam logic [4:0] ME = 5'h05; // strapped bus address
  logic clk;
  logic rst_n;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic busy;
  logic [4:0] straps;
  logic [4:0] phy_addr;
  logic frame_done;
  int miscompares;
  int n_checks;
  int done_cnt; // frames the slave finished
  smi_if smi_if_i ();
  smi_station smi_station_i (.clk(clk), .rst_n(rst_n), .bus(smi_if_i.station_manager), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));
  smi_phy_slave smi_phy_slave_i (.clk(clk), .rst_n(rst_n), .bus(smi_if_i.phy),
    .bus_address_straps(straps), .phy_addr(phy_addr), .frame_done(frame_done));
  smi_link_props smi_link_props_i (.clk(clk), .rst_n(rst_n), .mdc(smi_if_i.mdc),
    .sta_o(smi_if_i.sta_o), .sta_oe(smi_if_i.sta_oe), .phy_o(smi_if_i.phy_o),
    .phy_oe(smi_if_i.phy_oe), .mdio(smi_if_i.mdio));
  // clock and frame counter
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (frame_done === 1'b1) begin
      done_cnt++;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  // one register strobe each
  task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // one read strobe, data taken in the cycle after it
  task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd
  task automatic mr_frame(input logic [15:0] cmd, output logic [15:0] d);
    int n;
    logic [15:0] s;
    n = 0;
    bus_wr(smi_pkg::SMI_STA_CMD, cmd);
    bus_rd(smi_pkg::SMI_STA_STATUS, s);
    check(s, 16'h0001);
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) begin
      miscompares++;
    end
    bus_rd(smi_pkg::SMI_STA_RDATA, d);
  endtask : mr_frame
  task automatic mw(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] v);
    logic [15:0] d;
    bus_wr(smi_pkg::SMI_STA_WDATA, v);
    mr_frame({1'b1, 5'h00, ph, rg}, d);
  endtask : mw
  task automatic mr(input logic [4:0] ph, input logic [4:0] rg, input logic [15:0] exp);
    logic [15:0] d;
    mr_frame({1'b0, 5'h00, ph, rg}, d);
    check(d, exp);
  endtask : mr
  task automatic ctl(input logic [15:0] v);
    mw(ME, smi_pkg::SMI_REG_MMD_CTRL, v);
  endtask : ctl
  task automatic adw(input logic [15:0] v);
    mw(ME, smi_pkg::SMI_REG_MMD_ADDR_DATA, v);
  endtask : adw
  task automatic adr(input logic [15:0] exp);
    mr(ME, smi_pkg::SMI_REG_MMD_ADDR_DATA, exp);
  endtask : adr
  // straps latched once, later changes ignored
  task automatic t_direct();
    int d0;
    logic [15:0] d;
    repeat (6) @(posedge clk);
    straps <= 5'h1A;
    check({11'h000, phy_addr}, {11'h000, ME});
    mw(ME, 5'h03, 16'hA5C3);
    bus_rd(smi_pkg::SMI_STA_WDATA, d);
    check(d, 16'hA5C3);
    mw(ME, 5'h1F, 16'h1234);
    check(done_cnt[15:0], 16'h0002);
    mr(ME, 5'h03, 16'hA5C3);
    mr(ME, 5'h1F, 16'h1234);
    d0 = done_cnt;
    mw(5'h1A, 5'h03, 16'h0000);
    mr(5'h1A, 5'h03, 16'hFFFF);
    check(done_cnt[15:0], d0[15:0]);
    // management clock stopped for a long idle gap
    repeat (300) @(posedge clk);
    mr(ME, 5'h1F, 16'h1234);
    mr(ME, 5'h03, 16'hA5C3);
    $display("test direct done");
  endtask : t_direct
  // every function code on the pcs space
  task automatic t_modes();
    ctl(16'h0003);
    adw(16'h0002);
    adr(16'h0002);
    adr(16'h0002);
    ctl(16'h4003);
    adw(16'h1111);
    adw(16'h2222);
    adr(16'h2222);
    ctl(16'h0003);
    adr(16'h0002);
    ctl(16'h8003);
    adw(16'h3333);
    adr(16'h0000);
    ctl(16'h0003);
    adr(16'h0004);
    ctl(16'hC003);
    adr(16'h0000);
    adw(16'h4444);
    ctl(16'h0003);
    adr(16'h0005);
    adw(16'h0004);
    ctl(16'h4003);
    adr(16'h4444);
    $display("test modes done");
  endtask : t_modes
  // vendor space, blocked targets, bad selector
  task automatic t_vendor();
    ctl(16'h001F);
    adw(16'h0003);
    ctl(16'h401F);
    adr(16'hA5C3);
    ctl(16'h001F);
    adw(16'h000D);
    ctl(16'h401F);
    adr(16'h0000);
    adw(16'h9999);
    mr(ME, smi_pkg::SMI_REG_MMD_CTRL, 16'h401F);
    ctl(16'h0005);
    adw(16'h0009);
    ctl(16'h0003);
    adr(16'h000D);
    ctl(16'h4005);
    adr(16'h0000);
    ctl(16'h4007);
    adw(16'h7777);
    adr(16'h7777);
    $display("test vendor done");
  endtask : t_vendor
  // watchdog against a hung frame
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    addr = 2'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    straps = ME;
    miscompares = 0;
    n_checks = 0;
    done_cnt = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_direct();
    t_modes();
    t_vendor();
    report_and_stop();
  end
endmodule : test_smi_mmd_indirect_access
